// ### verilog/bcs_boot_clock_sequencer.sv
/*
 * Boot clock sequencer: power-up hold-off, internal fast oscillator
 * start, crystal stabilisation counting, STOP handling and a
 * glitch-free CPU clock selector with a small register port.
 * Assumes the oscillator clocks are much slower than clk_i so that
 * their levels can be sampled, and that STOP entry and release
 * pulses come from logic on clk_i.
 */
// Our own choices: the address map and the strobed register port.

module bcs_boot_clock_sequencer #(
    parameter int unsigned SUPPLY_WAIT_CYC = bcs_pkg::SUPPLY_STAB_CYC
) (
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        poc_above_low_i,
    input  wire logic                        poc_above_high_i,
    input  wire logic                        reset_pin_n_i,
    input  wire logic                        lowvolt_default_start_option_i,
    input  wire logic                        main_crystal_clock_i,
    input  wire logic                        sub_crystal_clock_i,
    input  wire logic                        internal_fast_osc_clock_i,
    input  wire logic                        stop_enter_i,
    input  wire logic                        stop_release_i,
    input  wire bcs_pkg::bcs_bus_req_s       bus_i,
    output logic [bcs_pkg::DATA_W-1:0]       rdata_o,
    output bcs_pkg::bcs_ctrl_out_s           ctrl_o,
    output bcs_pkg::bcs_sel_e                cpu_clk_sel_o,
    output logic                             cpu_clock_o
);
    import bcs_pkg::*;

    // =========================================================
    // State
    // =========================================================
    typedef struct packed {
        logic [SYN_W-1:0]        sync1;
        logic [SYN_W-1:0]        sync2;
        logic                    opt_sync1;
        logic                    opt_sync2;
        logic                    main_prev;
        bcs_state_e              state;
        logic [SUPPLY_CNT_W-1:0] supply_cnt;
        logic [4:0]              proc_cnt;
        logic [STAB_CNT_W-1:0]   stab_cnt;
        logic [7:0]              clk_ctrl;
        logic [2:0]              stab_sel;
        bcs_sel_e                cur_sel;
        logic                    cpu_clock;
        logic [DATA_W-1:0]       rdata;
        bcs_ctrl_out_s           outs;
    } bcs_regs_s;

    bcs_regs_s st_reg;
    bcs_regs_s st_next;

    // Count of crystal periods selected by a stabilisation code;
    // prohibited codes fall back to the longest wait.
    function automatic logic [STAB_CNT_W-1:0] stab_target(
        input logic [2:0] code
    );
        logic [STAB_CNT_W-1:0] one;
        one = {{(STAB_CNT_W-1){1'b0}}, 1'b1};
        unique case (code)
            3'h1:    stab_target = one << 11;
            3'h2:    stab_target = one << 13;
            3'h3:    stab_target = one << 14;
            3'h4:    stab_target = one << 15;
            default: stab_target = one << 16;
        endcase
    endfunction

    // Level of a source as seen through the synchroniser
    function automatic logic src_level(
        input bcs_sel_e         sel,
        input logic [SYN_W-1:0] s
    );
        unique case (sel)
            SEL_MAIN: src_level = s[SYN_MAIN];
            SEL_SUB:  src_level = s[SYN_SUB];
            default:  src_level = s[SYN_FAST];
        endcase
    endfunction

    // =========================================================
    // Next state
    // =========================================================
    logic [SYN_W-1:0]      pins;
    logic                  supply_ok;
    logic                  main_ext;
    logic                  cpu_started;
    logic                  stab_done;
    logic                  main_edge;
    logic [STAB_CODES-1:0] stab_status;
    logic                  src_ok;
    bcs_sel_e              req_sel;
    logic [7:0]            wctl;

    assign pins = {poc_above_high_i, poc_above_low_i, reset_pin_n_i,
                   internal_fast_osc_clock_i, sub_crystal_clock_i,
                   main_crystal_clock_i};

    // Status shows thresholds reached, capped by the selection, since
    // the counter stops at the selected count
    for (genvar g = 0; g < STAB_CODES; g++) begin : g_stab_status
        assign stab_status[g] = st_reg.clk_ctrl[CTL_MAIN_EXT] |
            (st_reg.stab_cnt >= stab_target(3'(g + 1)));
    end

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;
        st_next.main_prev = st_reg.sync2[SYN_MAIN];
        // The option may move while power is unsettled, so it is
        // filtered like the detector levels it chooses between
        st_next.opt_sync1 = lowvolt_default_start_option_i;
        st_next.opt_sync2 = st_reg.opt_sync1;

        main_ext = st_reg.clk_ctrl[CTL_MAIN_EXT];
        req_sel = bcs_sel_e'(st_reg.clk_ctrl[CTL_SEL_LO +: 2]);
        // Crystal selection and stop bits only count once the CPU
        // has been released
        cpu_started = (st_reg.state == ST_RUN) ||
            (st_reg.state == ST_WAKE) || (st_reg.state == ST_STOP);

        // Detector threshold depends on the default start option
        supply_ok = st_reg.sync2[SYN_RST_PIN] &
            (st_reg.opt_sync2 ?
             st_reg.sync2[SYN_POC_HIGH] :
             st_reg.sync2[SYN_POC_LOW]);

        main_edge = st_reg.sync2[SYN_MAIN] & ~st_reg.main_prev;
        stab_done = main_ext |
            (st_reg.stab_cnt >= stab_target(st_reg.stab_sel));

        // ----- Sequencer -----
        unique case (st_reg.state)
            ST_POWER_ON: begin
                st_next.supply_cnt = '0;
                if (supply_ok) begin
                    st_next.state = ST_SUPPLY;
                end
            end
            ST_SUPPLY: begin
                // Also covers fast oscillator accuracy settling
                if (st_reg.supply_cnt >=
                    SUPPLY_CNT_W'(SUPPLY_WAIT_CYC - 1)) begin
                    st_next.state = ST_RESET_PROC;
                    st_next.proc_cnt = '0;
                end else begin
                    st_next.supply_cnt = st_reg.supply_cnt + 1'b1;
                end
            end
            ST_RESET_PROC: begin
                if (st_reg.proc_cnt >= RESET_PROC_CYC - 5'h01) begin
                    st_next.state = ST_RUN;
                end else begin
                    st_next.proc_cnt = st_reg.proc_cnt + 1'b1;
                end
            end
            ST_RUN: begin
                if (stop_enter_i) begin
                    st_next.state = ST_STOP;
                end
            end
            ST_STOP: begin
                if (stop_release_i) begin
                    st_next.state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // Only a main crystal CPU clock has to wait
                if (st_reg.cur_sel != SEL_MAIN || stab_done) begin
                    st_next.state = ST_RUN;
                end
            end
            default: begin
                st_next.state = ST_POWER_ON;
            end
        endcase

        // Supply loss or reset pin forces the whole sequence again
        if (!supply_ok) begin
            st_next.state = ST_POWER_ON;
        end

        // ----- Register writes -----
        if (bus_i.we && bus_i.addr == ADDR_CLK_CTRL) begin
            wctl = bus_i.wdata;
            // The source feeding the CPU cannot be stopped
            unique case (st_reg.cur_sel)
                SEL_MAIN: wctl[CTL_MAIN_STOP] = 1'b0;
                SEL_SUB:  wctl[CTL_SUB_STOP] = 1'b0;
                default:  wctl[CTL_FAST_STOP] = 1'b0;
            endcase
            st_next.clk_ctrl = wctl;
        end else begin
            wctl = st_reg.clk_ctrl;
        end
        if (bus_i.we && bus_i.addr == ADDR_STAB_SEL) begin
            st_next.stab_sel = bus_i.wdata[2:0];
        end
        // Early clock control writes do not stick: the boot keeps the fast clock and
        // both crystals stopped until the CPU runs
        if (!cpu_started) begin
            st_next.clk_ctrl = CLK_CTRL_RST;
        end

        // ----- Reset, run and oscillator enable outputs (registered) -----
        st_next.outs.chip_reset_n = (st_next.state != ST_POWER_ON);
        st_next.outs.reset_proc = (st_next.state == ST_RESET_PROC);
        st_next.outs.cpu_run = (st_next.state == ST_RUN);
        st_next.outs.fast_en = (st_next.state != ST_POWER_ON) &
            (st_next.state != ST_STOP) &
            ~st_next.clk_ctrl[CTL_FAST_STOP];
        st_next.outs.main_en = (st_next.state == ST_RUN ||
            st_next.state == ST_WAKE) &
            ~st_next.clk_ctrl[CTL_MAIN_STOP];
        st_next.outs.sub_en = (st_next.state != ST_POWER_ON) &
            ~st_next.clk_ctrl[CTL_SUB_STOP];

        // ----- Crystal stabilisation counter -----
        if (!st_reg.outs.main_en || main_ext) begin
            st_next.stab_cnt = '0;
        end else if (main_edge && !stab_done) begin
            st_next.stab_cnt = st_reg.stab_cnt + 1'b1;
        end

        // ----- Glitch-free source switch -----
        // A target whose stop bit lands in this very cycle is refused,
        // otherwise the CPU could end up on a stopped source
        unique case (req_sel)
            SEL_MAIN: src_ok = st_reg.outs.main_en & st_next.outs.main_en;
            SEL_SUB:  src_ok = st_reg.outs.sub_en & st_next.outs.sub_en;
            default:  src_ok = st_reg.outs.fast_en & st_next.outs.fast_en;
        endcase
        // Only before the CPU starts is the fast clock forced
        if (!cpu_started) begin
            req_sel = SEL_FAST;
            src_ok = 1'b1;
        end
        // Hand over only while both clocks sit low
        if (req_sel != st_reg.cur_sel && src_ok &&
            !st_reg.cpu_clock &&
            !src_level(req_sel, st_reg.sync2)) begin
            st_next.cur_sel = req_sel;
            st_next.cpu_clock = 1'b0;
        end else begin
            st_next.cpu_clock =
                src_level(st_reg.cur_sel, st_reg.sync2);
        end

        // ----- Register reads, data in the following cycle -----
        st_next.rdata = '0;
        if (bus_i.re) begin
            unique case (bus_i.addr)
                ADDR_CLK_CTRL:    st_next.rdata = st_reg.clk_ctrl;
                ADDR_STAB_SEL:    st_next.rdata = {5'h00, st_reg.stab_sel};
                ADDR_STAB_STATUS: st_next.rdata = {3'h0, stab_status};
                ADDR_CLK_STATUS:  st_next.rdata = {
                    st_reg.outs.cpu_run, st_reg.outs.sub_en,
                    st_reg.outs.main_en, st_reg.outs.fast_en,
                    stab_done, st_reg.state[0], st_reg.cur_sel};
                default:          st_next.rdata = '0;
            endcase
        end
    end

    // =========================================================
    // Registers
    // =========================================================
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '{
                sync1:      '0,
                sync2:      '0,
                opt_sync1:  1'b0,
                opt_sync2:  1'b0,
                main_prev:  1'b0,
                state:      ST_POWER_ON,
                supply_cnt: '0,
                proc_cnt:   '0,
                stab_cnt:   '0,
                clk_ctrl:   CLK_CTRL_RST,
                stab_sel:   STAB_SEL_RST,
                cur_sel:    SEL_FAST,
                cpu_clock:  1'b0,
                rdata:      '0,
                outs:       '0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    assign rdata_o = st_reg.rdata;
    assign ctrl_o = st_reg.outs;
    assign cpu_clk_sel_o = st_reg.cur_sel;
    assign cpu_clock_o = st_reg.cpu_clock;

endmodule

// ### verilog/bcs_pkg.sv
/*
 * Constants and state types for the boot clock sequencer.
 * Assumes a single 50 MHz system clock; oscillator levels and
 * supply detector levels arrive asynchronously as pins.
 */
package bcs_pkg;

    // =========================================================
    // Clock and timing
    // =========================================================
    localparam int unsigned CLK_PERIOD_NS     = 20;
    localparam int unsigned SUPPLY_STAB_NS    = 930_000;
    localparam int unsigned SUPPLY_STAB_CYC   =
        (SUPPLY_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SUPPLY_CNT_W      = 17;
    localparam logic [4:0]  RESET_PROC_CYC    = 5'h10;

    // =========================================================
    // Register map (byte-wide, 4-bit address)
    // =========================================================
    localparam int unsigned ADDR_W            = 4;
    localparam int unsigned DATA_W            = 8;
    localparam logic [3:0]  ADDR_CLK_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_STAB_SEL     = 4'h1;
    localparam logic [3:0]  ADDR_STAB_STATUS  = 4'h2;
    localparam logic [3:0]  ADDR_CLK_STATUS   = 4'h3;

    // Clock control field positions
    localparam int unsigned CTL_MAIN_STOP     = 0;
    localparam int unsigned CTL_SUB_STOP      = 1;
    localparam int unsigned CTL_FAST_STOP     = 2;
    localparam int unsigned CTL_MAIN_EXT      = 3;
    localparam int unsigned CTL_SUB_EXT       = 4;
    localparam int unsigned CTL_SEL_LO        = 5;
    localparam logic [7:0]  CLK_CTRL_RST      = 8'h03;

    // Stabilisation time select
    localparam logic [2:0]  STAB_SEL_RST      = 3'h5;
    localparam int unsigned STAB_CNT_W        = 17;
    localparam int unsigned STAB_CODES        = 5;

    // Pin synchroniser lanes
    localparam int unsigned SYN_MAIN          = 0;
    localparam int unsigned SYN_SUB           = 1;
    localparam int unsigned SYN_FAST          = 2;
    localparam int unsigned SYN_RST_PIN       = 3;
    localparam int unsigned SYN_POC_LOW       = 4;
    localparam int unsigned SYN_POC_HIGH      = 5;
    localparam int unsigned SYN_W             = 6;

    // =========================================================
    // Types
    // =========================================================
    typedef enum logic [1:0] {
        SEL_FAST = 2'b00,
        SEL_MAIN = 2'b01,
        SEL_SUB  = 2'b10
    } bcs_sel_e;

    typedef enum logic [2:0] {
        ST_POWER_ON   = 3'b000,
        ST_SUPPLY     = 3'b001,
        ST_RESET_PROC = 3'b011,
        ST_RUN        = 3'b010,
        ST_STOP       = 3'b110,
        ST_WAKE       = 3'b111
    } bcs_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } bcs_bus_req_s;

    typedef struct packed {
        logic chip_reset_n;
        logic reset_proc;
        logic cpu_run;
        logic fast_en;
        logic main_en;
        logic sub_en;
    } bcs_ctrl_out_s;

endpackage

// ### tb/bcs_checker_assertions.sv
/*
 * Port-level checker for the boot clock sequencer.
 * Assumes one clock domain and the synchronous active-low reset.
 */
module bcs_checker
    import bcs_pkg::*;
#(
    parameter int unsigned SUPPLY_WAIT_CYC = 20
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   stop_enter_i,
    input  wire bcs_pkg::bcs_ctrl_out_s ctrl_o,
    input  wire bcs_pkg::bcs_sel_e      cpu_clk_sel_o,
    input  wire logic                   cpu_clock_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // =========================================================
    // Supply settling length, counted outside the CPU run
    // =========================================================
    logic [31:0] hold_cnt_reg;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !ctrl_o.chip_reset_n) begin
            hold_cnt_reg <= '0;
        end else if (!ctrl_o.reset_proc && !ctrl_o.cpu_run) begin
            hold_cnt_reg <= hold_cnt_reg + 32'd1;
        end
    end

    // =========================================================
    // Properties
    // =========================================================
    a_no_run_reset: assert property (
        !ctrl_o.chip_reset_n |-> !ctrl_o.cpu_run && !ctrl_o.fast_en
            && !ctrl_o.main_en && !ctrl_o.sub_en)
        else $error("clock activity while reset held");
    a_fast_on_release: assert property (
        $rose(ctrl_o.chip_reset_n) |-> ctrl_o.fast_en && !ctrl_o.main_en
            && !ctrl_o.sub_en)
        else $error("release without fast oscillator alone");
    a_start_on_fast: assert property (
        $rose(ctrl_o.cpu_run) && $past(ctrl_o.reset_proc)
            |-> cpu_clk_sel_o == SEL_FAST)
        else $error("CPU started on a crystal");
    a_reset_proc_len: assert property (
        $rose(ctrl_o.reset_proc) |-> ctrl_o.reset_proc [*8]
            ##[8:10] (ctrl_o.cpu_run && !ctrl_o.reset_proc))
        else $error("reset processing length wrong");
    a_supply_wait: assert property (
        $rose(ctrl_o.reset_proc) |-> hold_cnt_reg >= SUPPLY_WAIT_CYC - 1)
        else $error("supply settling interval too short");
    a_stop_halts: assert property (
        stop_enter_i && ctrl_o.cpu_run |-> ##1 (!ctrl_o.fast_en
            && !ctrl_o.main_en && !ctrl_o.cpu_run))
        else $error("STOP left a fast clock running");
    a_sel_main_on: assert property (
        ctrl_o.cpu_run && cpu_clk_sel_o == SEL_MAIN |-> ctrl_o.main_en)
        else $error("selected main clock stopped");
    a_switch_quiet: assert property (
        $changed(cpu_clk_sel_o) |-> !cpu_clock_o)
        else $error("clock high during source change");
endmodule

bind bcs_boot_clock_sequencer bcs_checker #(
    .SUPPLY_WAIT_CYC(SUPPLY_WAIT_CYC)
) u_chk (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .stop_enter_i (stop_enter_i),
    .ctrl_o       (ctrl_o),
    .cpu_clk_sel_o(cpu_clk_sel_o),
    .cpu_clock_o  (cpu_clock_o)
);

// ### tb/bcs_supply_model.sv
/*
 * Supply ramp and external reset source model.
 * Assumes supply level in millivolts; detector levels are thresholds.
 */
module bcs_supply_model #(
    parameter int unsigned LOW_MV  = 1610,
    parameter int unsigned HIGH_MV = 1910,
    parameter int unsigned PIN_MV  = 1800
) (
    input  wire logic        slow_ramp_i,
    input  wire logic        option_i,
    input  wire logic [15:0] supply_mv_i,
    output logic             poc_above_low_o,
    output logic             poc_above_high_o,
    output logic             reset_pin_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign poc_above_low_o  = supply_mv_i > LOW_MV;
    assign poc_above_high_o = supply_mv_i > HIGH_MV;
    // Slow ramp without the option: board holds the pin until 1.8 V
    assign reset_pin_n_o    = !(slow_ramp_i && !option_i
                                && supply_mv_i < PIN_MV);
endmodule

// ### tb/bcs_boot_clock_sequencer_tb_top.sv
/*
 * Self-checking bench for the boot clock sequencer.
 * Assumes the supply model drives detector and reset pin levels.
 */
module bcs_boot_clock_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import bcs_pkg::*;
    localparam int unsigned W = 20;
    localparam int unsigned T11 = 2048 * 8;
    logic          clk_i = 0, rst_n_i = 0, opt = 0, slow = 0, re_d = 0;
    logic          m_clk = 0, s_clk = 0, f_clk = 0, stp_e = 0, stp_r = 0;
    logic [15:0]   mv = 0;
    logic [7:0]    ph = 0, rdata;
    bcs_bus_req_s  bus = '0;
    bcs_ctrl_out_s ctrl;
    bcs_sel_e      sel;
    logic          cpu_clock, poc_lo, poc_hi, pin_n;
    logic [7:0]    exp_q[$];
    int            fail_count = 0, tests_run = 0, cyc = 0, n;

    bcs_supply_model u_sup (.slow_ramp_i(slow), .option_i(opt),
        .supply_mv_i(mv), .poc_above_low_o(poc_lo),
        .poc_above_high_o(poc_hi), .reset_pin_n_o(pin_n));
    bcs_boot_clock_sequencer #(.SUPPLY_WAIT_CYC(W)) dut (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .poc_above_low_i(poc_lo),
        .poc_above_high_i(poc_hi), .reset_pin_n_i(pin_n),
        .lowvolt_default_start_option_i(opt), .main_crystal_clock_i(m_clk),
        .sub_crystal_clock_i(s_clk), .internal_fast_osc_clock_i(f_clk),
        .stop_enter_i(stp_e), .stop_release_i(stp_r), .bus_i(bus),
        .rdata_o(rdata), .ctrl_o(ctrl), .cpu_clk_sel_o(sel),
        .cpu_clock_o(cpu_clock));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // Oscillators only swing while enabled, well below clk_i
    always @(posedge clk_i) begin
        ph <= ph + 8'd1;
        if (ctrl.main_en === 1'b1 && ph[1:0] == 2'd3) m_clk <= ~m_clk;
        if (ctrl.sub_en === 1'b1 && ph[3:0] == 4'd15) s_clk <= ~s_clk;
        if (ctrl.fast_en === 1'b1) f_clk <= ph[1];
    end

    // =========================================================
    // Result watcher and hang guard
    // =========================================================
    always @(posedge clk_i) begin
        if (re_d) cmp8(rdata, exp_q.pop_front());
        re_d <= bus.re;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk_i);
        bus <= '0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clk_i);
        bus <= '0;
        @(posedge clk_i);
    endtask
    task automatic power(input logic [15:0] v, input logic o, s, e);
        mv <= v;
        opt <= o;
        slow <= s;
        // Two sync flops and one state edge, then a margin; a fixed
        // wait also catches a supply drop while still released
        repeat (5) @(posedge clk_i);
        cmp1(ctrl.chip_reset_n === e && ctrl.fast_en === e, "release");
    endtask
    task automatic pulse(input logic enter);
        if (enter) stp_e <= 1'b1; else stp_r <= 1'b1;
        @(posedge clk_i);
        stp_e <= 1'b0;
        stp_r <= 1'b0;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        n = $urandom(69271);
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        power(16'd0, 1'b0, 1'b0, 1'b0);
        power(16'd1611 + 16'($urandom % 290), 1'b1, 1'b0, 1'b0);
        power(16'd2000, 1'b1, 1'b0, 1'b1);
        power(16'd0, 1'b0, 1'b1, 1'b0);
        power(16'd1611 + 16'($urandom % 180), 1'b0, 1'b1, 1'b0);
        power(16'd1850, 1'b0, 1'b1, 1'b1);
        power(16'd0, 1'b0, 1'b0, 1'b0);
        power(16'd1611 + 16'($urandom % 290), 1'b0, 1'b0, 1'b1);
        for (n = 0; n < 200 && ctrl.cpu_run !== 1'b1; n++) @(posedge clk_i);
        cmp1(n >= W + 15 && n <= W + 17, "start delay");
        cmp1(sel === SEL_FAST, "start source");
        $display("test power sequencing done");
        rd(ADDR_STAB_SEL, 8'h05);
        rd(ADDR_CLK_CTRL, CLK_CTRL_RST);
        rd(4'hF, 8'h00);
        wr(ADDR_STAB_SEL, 8'h01);
        wr(ADDR_CLK_CTRL, 8'h02);
        rd(ADDR_STAB_STATUS, 8'h00);
        repeat (T11 + 64) @(posedge clk_i);
        rd(ADDR_STAB_STATUS, 8'h01);
        wr(ADDR_CLK_CTRL, 8'h22);
        for (n = 0; n < 100 && sel !== SEL_MAIN; n++) @(posedge clk_i);
        cmp1(sel === SEL_MAIN, "switch to main");
        wr(ADDR_CLK_CTRL, 8'h27);
        rd(ADDR_CLK_CTRL, 8'h26);
        repeat (4) @(posedge clk_i);
        cmp1(ctrl.fast_en === 1'b0 && ctrl.main_en === 1'b1, "stop");
        $display("test crystal switch done");
        pulse(1'b1);
        repeat (3) @(posedge clk_i);
        cmp1(ctrl.cpu_run === 1'b0 && ctrl.main_en === 1'b0, "halt");
        pulse(1'b0);
        for (n = 0; n < 20000 && ctrl.cpu_run !== 1'b1; n++) @(posedge clk_i);
        cmp1(n >= T11 - 16 && n <= T11 + 64, "wake hold");
        wr(ADDR_CLK_CTRL, 8'h2E);
        rd(ADDR_STAB_STATUS, 8'h1F);
        repeat (2) @(posedge clk_i);
        $display("test stop and wake done");
        complete_run();
    end
endmodule
